// [design/sfc_front_end.sv]
`timescale 1ns/100ps
`include "sfc_params.svh"
module sfc_front_end
   import sfc_pkg::*;
(
   // system clock and power-on reset
   input wire logic sys_clk_in,
   input wire logic reset_in,
   // serial link pins
   input wire logic sclk_in,
   input wire logic cs_n_in,
   input wire logic si_in,
   output logic so_out,
   output logic so_oe_out,
   // control pins and configuration
   input wire logic wp_n_in,
   input wire logic rst_pin_n_in,
   input wire logic page_bin_in,
   // array side status
   input wire logic busy_in,
   output logic hw_protect_out,
   output logic hold_reset_out,
   output logic standby_out,
   // command issue
   output logic cmd_valid_out,
   output sfc_kind_e cmd_kind_out,
   output sfc_tgt_e cmd_tgt_out,
   output logic [11:0] cmd_page_out,
   output logic [8:0] cmd_off_out,
   // write data into buffer or protection register
   output logic wr_valid_out,
   output logic [7:0] wr_data_out,
   output logic [8:0] wr_off_out,
   // read data fetch, data due one cycle after request
   output logic rd_req_out,
   output sfc_tgt_e rd_tgt_out,
   output logic [11:0] rd_page_out,
   output logic [8:0] rd_off_out,
   input wire logic [7:0] rd_data_in
);
   sfc_link_if #(.WORD_W(`SFC_WORD_W)) lk ();

   logic link_rst;

   // deselect, power-on reset or reset pin all clear the link side
   assign link_rst = cs_n_in | reset_in | ~rst_pin_n_in;
   assign so_oe_out = ~link_rst;

   sfc_link_shift #(.WORD_W(`SFC_WORD_W)) u_link (
      .sclk_in(sclk_in),
      .link_rst_in(link_rst),
      .si_in(si_in),
      .so_out(so_out),
      .lk(lk)
   );

   // split a right-aligned address by page size
   function automatic sfc_loc_s split_addr(input logic [23:0] a,
                                           input logic bin);
      sfc_loc_s l;
      if (bin) begin
         l.page = a[`SFC_BIN_OFF_W +: `SFC_PAGE_W];
         l.off = {1'b0, a[`SFC_BIN_OFF_W-1:0]};
      end else begin
         l.page = a[`SFC_STD_OFF_W +: `SFC_PAGE_W];
         l.off = a[`SFC_STD_OFF_W-1:0];
      end
      return l;
   endfunction

   // step one byte; main memory crosses pages, buffers wrap
   function automatic sfc_loc_s next_loc(input sfc_loc_s l,
                                         input logic main,
                                         input logic bin);
      sfc_loc_s n;
      logic [8:0] last;
      n = l;
      last = bin ? `SFC_BIN_LAST : `SFC_STD_LAST;
      if (l.off == last) begin
         n.off = '0;
         if (main) begin
            n.page = l.page + 12'h001;
         end
      end else begin
         n.off = l.off + 9'h001;
      end
      return n;
   endfunction

   // opcode decoder
   function automatic sfc_dec_s decode(input logic [7:0] op);
      sfc_dec_s d;
      d = '{kind: CK_NONE, tgt: TGT_MAIN, need_addr: 1'b1};
      unique case (op)
         `SFC_OP_READ_MAIN: d.kind = CK_READ;
         `SFC_OP_READ_BUF1: d = '{CK_READ, TGT_BUF1, 1'b1};
         `SFC_OP_READ_BUF2: d = '{CK_READ, TGT_BUF2, 1'b1};
         `SFC_OP_PROG_BUF1: d = '{CK_PROGRAM, TGT_BUF1, 1'b1};
         `SFC_OP_PROG_BUF2: d = '{CK_PROGRAM, TGT_BUF2, 1'b1};
         `SFC_OP_ERASE_PAGE: d.kind = CK_ERASE_PAGE;
         `SFC_OP_ERASE_BLOCK: d.kind = CK_ERASE_BLOCK;
         `SFC_OP_ERASE_SECTOR: d.kind = CK_ERASE_SECTOR;
         `SFC_OP_ERASE_CHIP: d = '{CK_ERASE_CHIP, TGT_MAIN, 1'b0};
         `SFC_OP_PROT_ENABLE: d = '{CK_PROT_ENABLE, TGT_MAIN, 1'b0};
         `SFC_OP_LOCKDOWN: d.kind = CK_LOCKDOWN;
         `SFC_OP_PROT_WRITE: d = '{CK_PROT_WRITE, TGT_MAIN, 1'b0};
         default: d.kind = CK_NONE;
      endcase
      return d;
   endfunction

   // pin and toggle synchronisers
   logic cs_s1_reg, cs_s2_reg, wp_s1_reg, wp_s2_reg;
   logic rp_s1_reg, rp_s2_reg, tg_s1_reg, tg_s2_reg;

   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         cs_s1_reg <= 1'b1;
         cs_s2_reg <= 1'b1;
         wp_s1_reg <= 1'b1;
         wp_s2_reg <= 1'b1;
         rp_s1_reg <= 1'b1;
         rp_s2_reg <= 1'b1;
         tg_s1_reg <= 1'b0;
         tg_s2_reg <= 1'b0;
      end else begin
         cs_s1_reg <= cs_n_in;
         cs_s2_reg <= cs_s1_reg;
         wp_s1_reg <= wp_n_in;
         wp_s2_reg <= wp_s1_reg;
         rp_s1_reg <= rst_pin_n_in;
         rp_s2_reg <= rp_s1_reg;
         tg_s1_reg <= lk.rx_tgl;
         tg_s2_reg <= tg_s1_reg;
      end
   end

   sfc_state_e state_reg, state_next;
   sfc_dec_s dec_reg, dec_next;
   sfc_loc_s loc_reg, loc_next, rd_loc_reg, rd_loc_next;
   logic [23:0] addr_reg, addr_next;
   logic [1:0] acnt_reg, acnt_next;
   logic tg_last_reg, cs_d_reg, rd_pend_reg;
   logic [7:0] tx_byte_reg, tx_byte_next;
   logic cmd_valid_next, wr_valid_next, rd_req_next;
   sfc_kind_e cmd_kind_next;
   sfc_tgt_e cmd_tgt_next;
   sfc_loc_s cmd_loc_reg, cmd_loc_next;
   logic [7:0] wr_data_next;
   logic [8:0] wr_off_next;
   logic standby_next;
   logic byte_ev, start_ev, end_ev, wp_low, pin_rst, pe_cmd;
   sfc_dec_s dec_now;
   sfc_loc_s loc_addr;
   logic [23:0] addr_shift;

   // frame events seen from the system side
   assign byte_ev = (tg_s2_reg != tg_last_reg) & ~cs_s2_reg;
   assign start_ev = cs_d_reg & ~cs_s2_reg;
   assign end_ev = cs_s2_reg & ~cs_d_reg;
   assign wp_low = ~wp_s2_reg;
   assign pin_rst = ~rp_s2_reg;
   assign dec_now = decode(lk.rx_byte);
   assign addr_shift = {addr_reg[15:0], lk.rx_byte};
   assign loc_addr = split_addr(addr_shift, page_bin_in);
   assign pe_cmd = dec_now.kind inside {CK_PROGRAM, CK_ERASE_PAGE,
      CK_ERASE_BLOCK, CK_ERASE_SECTOR, CK_ERASE_CHIP};

   // instruction framing controller
   always_comb begin
      state_next = state_reg;
      dec_next = dec_reg;
      loc_next = loc_reg;
      rd_loc_next = rd_loc_reg;
      addr_next = addr_reg;
      acnt_next = acnt_reg;
      tx_byte_next = rd_pend_reg ? rd_data_in : tx_byte_reg;
      cmd_valid_next = 1'b0;
      cmd_kind_next = cmd_kind_out;
      cmd_tgt_next = cmd_tgt_out;
      cmd_loc_next = cmd_loc_reg;
      wr_valid_next = 1'b0;
      wr_data_next = wr_data_out;
      wr_off_next = wr_off_out;
      rd_req_next = 1'b0;
      standby_next = cs_s2_reg & ~busy_in;
      unique case (state_reg)
         ST_IDLE: begin
            if (start_ev) begin
               state_next = ST_OPC;
            end
         end
         ST_OPC: begin
            if (byte_ev) begin
               dec_next = dec_now;
               addr_next = '0;
               acnt_next = '0;
               if (dec_now.kind == CK_NONE) begin
                  state_next = ST_DISC;
               end else if (pe_cmd && (wp_low || busy_in)) begin
                  state_next = ST_DISC;
               end else if (dec_now.kind == CK_PROT_WRITE && wp_low) begin
                  state_next = ST_DISC;
               end else if (dec_now.need_addr) begin
                  state_next = ST_ADDR;
               end else begin
                  state_next = ST_DATA;
               end
            end
         end
         ST_ADDR: begin
            if (byte_ev) begin
               addr_next = addr_shift;
               acnt_next = acnt_reg + 2'h1;
               if (acnt_reg == `SFC_ADDR_LAST) begin
                  state_next = ST_DATA;
                  loc_next = loc_addr;
                  cmd_loc_next = loc_addr;
                  rd_loc_next = loc_addr;
                  rd_req_next = (dec_reg.kind == CK_READ);
               end
            end
         end
         ST_DATA: begin
            if (byte_ev && dec_reg.kind == CK_READ) begin
               loc_next = next_loc(loc_reg, dec_reg.tgt == TGT_MAIN,
                                   page_bin_in);
               rd_loc_next = loc_next;
               rd_req_next = 1'b1;
            end else if (byte_ev && dec_reg.kind inside
                         {CK_PROGRAM, CK_PROT_WRITE}) begin
               wr_valid_next = 1'b1;
               wr_data_next = lk.rx_byte;
               wr_off_next = loc_reg.off;
               loc_next = next_loc(loc_reg, 1'b0, page_bin_in);
            end
         end
         ST_DISC: begin
            state_next = ST_DISC;
         end
         default: state_next = ST_IDLE;
      endcase
      // deselect closes the frame; only complete instructions issue
      if (end_ev && state_reg != ST_IDLE) begin
         state_next = ST_IDLE;
         if (state_reg == ST_DATA && dec_reg.kind != CK_READ) begin
            cmd_valid_next = 1'b1;
            cmd_kind_next = dec_reg.kind;
            cmd_tgt_next = dec_reg.tgt;
         end
      end
      if (pin_rst) begin
         state_next = ST_IDLE;
         cmd_valid_next = 1'b0;
         wr_valid_next = 1'b0;
         rd_req_next = 1'b0;
      end
   end

   // controller registers; reset_in is the power-on reset
   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         state_reg <= ST_IDLE;
         dec_reg <= '{kind: CK_NONE, tgt: TGT_MAIN, need_addr: 1'b0};
         loc_reg <= '0;
         rd_loc_reg <= '0;
         cmd_loc_reg <= '0;
         addr_reg <= '0;
         acnt_reg <= '0;
         tg_last_reg <= 1'b0;
         cs_d_reg <= 1'b1;
         rd_pend_reg <= 1'b0;
         tx_byte_reg <= '0;
         cmd_valid_out <= 1'b0;
         cmd_kind_out <= CK_NONE;
         cmd_tgt_out <= TGT_MAIN;
         wr_valid_out <= 1'b0;
         wr_data_out <= '0;
         wr_off_out <= '0;
         rd_req_out <= 1'b0;
         hw_protect_out <= 1'b0;
         hold_reset_out <= 1'b0;
         standby_out <= 1'b0;
      end else begin
         state_reg <= state_next;
         dec_reg <= dec_next;
         loc_reg <= loc_next;
         rd_loc_reg <= rd_loc_next;
         cmd_loc_reg <= cmd_loc_next;
         addr_reg <= addr_next;
         acnt_reg <= acnt_next;
         tg_last_reg <= tg_s2_reg;
         cs_d_reg <= cs_s2_reg;
         rd_pend_reg <= rd_req_out;
         tx_byte_reg <= tx_byte_next;
         cmd_valid_out <= cmd_valid_next;
         cmd_kind_out <= cmd_kind_next;
         cmd_tgt_out <= cmd_tgt_next;
         wr_valid_out <= wr_valid_next;
         wr_data_out <= wr_data_next;
         wr_off_out <= wr_off_next;
         rd_req_out <= rd_req_next;
         hw_protect_out <= wp_low;
         hold_reset_out <= pin_rst;
         standby_out <= standby_next;
      end
   end

   // outputs from registered locations
   assign cmd_page_out = cmd_loc_reg.page;
   assign cmd_off_out = cmd_loc_reg.off;
   assign rd_tgt_out = dec_reg.tgt;
   assign rd_page_out = rd_loc_reg.page;
   assign rd_off_out = rd_loc_reg.off;
   assign lk.tx_byte = tx_byte_reg;
endmodule

// [design/sfc_params.svh]
`ifndef SFC_PARAMS_SVH
`define SFC_PARAMS_SVH

// link word and address framing
`define SFC_WORD_W 8
`define SFC_ADDR_LAST 2'h2
`define SFC_ADDR_W 24
`define SFC_PAGE_W 12
`define SFC_OFF_W 9
`define SFC_BIN_OFF_W 8
`define SFC_STD_OFF_W 9

// last byte position in a page or buffer
`define SFC_BIN_LAST 9'h0ff
`define SFC_STD_LAST 9'h107

// instruction opcodes (values are this block's own)
`define SFC_OP_READ_MAIN 8'h11
`define SFC_OP_READ_BUF1 8'h12
`define SFC_OP_READ_BUF2 8'h13
`define SFC_OP_PROG_BUF1 8'h21
`define SFC_OP_PROG_BUF2 8'h22
`define SFC_OP_ERASE_PAGE 8'h31
`define SFC_OP_ERASE_BLOCK 8'h32
`define SFC_OP_ERASE_SECTOR 8'h33
`define SFC_OP_ERASE_CHIP 8'h34
`define SFC_OP_PROT_ENABLE 8'h41
`define SFC_OP_LOCKDOWN 8'h42
`define SFC_OP_PROT_WRITE 8'h43

`endif

// [design/sfc_pkg.sv]
package sfc_pkg;

   // controller states, one-hot
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_OPC = 5'h02,
      ST_ADDR = 5'h04,
      ST_DATA = 5'h08,
      ST_DISC = 5'h10
   } sfc_state_e;

   // decoded instruction kinds
   typedef enum logic [3:0] {
      CK_NONE = 4'h0,
      CK_READ = 4'h1,
      CK_PROGRAM = 4'h2,
      CK_ERASE_PAGE = 4'h3,
      CK_ERASE_BLOCK = 4'h4,
      CK_ERASE_SECTOR = 4'h5,
      CK_ERASE_CHIP = 4'h6,
      CK_PROT_ENABLE = 4'h7,
      CK_LOCKDOWN = 4'h8,
      CK_PROT_WRITE = 4'h9
   } sfc_kind_e;

   // data source or sink
   typedef enum logic [1:0] {
      TGT_MAIN = 2'h0,
      TGT_BUF1 = 2'h1,
      TGT_BUF2 = 2'h2
   } sfc_tgt_e;

   typedef struct packed {
      sfc_kind_e kind;
      sfc_tgt_e tgt;
      logic need_addr;
   } sfc_dec_s;

   typedef struct packed {
      logic [11:0] page;
      logic [8:0] off;
   } sfc_loc_s;

endpackage

// [design/sfc_link_if.sv]
`timescale 1ns/100ps
interface sfc_link_if #(
   parameter int WORD_W = 8
);
   logic [WORD_W-1:0] rx_byte;
   logic rx_tgl;
   logic [WORD_W-1:0] tx_byte;

   modport link (output rx_byte, output rx_tgl, input tx_byte);
   modport core (input rx_byte, input rx_tgl, output tx_byte);
endinterface

// [design/sfc_link_shift.sv]
`timescale 1ns/100ps
module sfc_link_shift
   import sfc_pkg::*;
#(
   parameter int WORD_W = 8
) (
   // link clock and frame reset
   input wire logic sclk_in,
   input wire logic link_rst_in,
   // serial data
   input wire logic si_in,
   output logic so_out,
   // towards the core
   sfc_link_if.link lk
);
   localparam int CNT_W = $clog2(WORD_W);

   if (WORD_W < 2 || WORD_W != (1 << CNT_W)) begin : g_chk
      $error("sfc_link_shift: WORD_W must be a power of two >= 2");
   end

   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic [WORD_W-1:0] rx_sh_reg, rx_sh_next;
   logic [WORD_W-1:0] rx_byte_reg, rx_byte_next;
   logic tgl_reg, tgl_next;
   logic [WORD_W-1:0] tx_sh_reg, tx_sh_next;

   // receive shifter, msb first, one toggle per whole word
   always_comb begin
      rx_sh_next = {rx_sh_reg[WORD_W-2:0], si_in};
      rx_byte_reg_hold: begin
         rx_byte_next = rx_byte_reg;
         tgl_next = tgl_reg;
      end
      if (cnt_reg == CNT_W'(WORD_W - 1)) begin
         cnt_next = '0;
         rx_byte_next = rx_sh_next;
         tgl_next = ~tgl_reg;
      end else begin
         cnt_next = cnt_reg + CNT_W'(1);
      end
   end

   // frame reset clears everything, so bits after deselect are lost
   always_ff @(posedge sclk_in or posedge link_rst_in) begin
      if (link_rst_in) begin
         cnt_reg <= '0;
         rx_sh_reg <= '0;
         rx_byte_reg <= '0;
         tgl_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         rx_sh_reg <= rx_sh_next;
         rx_byte_reg <= rx_byte_next;
         tgl_reg <= tgl_next;
      end
   end

   // transmit shifter, loads on each falling edge that finds the bit count at zero
   always_comb begin
      if (cnt_reg == '0) begin
         tx_sh_next = lk.tx_byte;
      end else begin
         tx_sh_next = {tx_sh_reg[WORD_W-2:0], 1'b0};
      end
   end

   always_ff @(negedge sclk_in or posedge link_rst_in) begin
      if (link_rst_in) begin
         tx_sh_reg <= '0;
      end else begin
         tx_sh_reg <= tx_sh_next;
      end
   end

   assign so_out = tx_sh_reg[WORD_W-1];
   assign lk.rx_byte = rx_byte_reg;
   assign lk.rx_tgl = tgl_reg;
endmodule

// [tb/sfc_fe_monitor.sv]
`timescale 1ns/100ps
`include "sfc_params.svh"
module sfc_fe_monitor
   import sfc_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic reset_in,
   // pins and strobes watched
   input wire logic cs_n_in,
   input wire logic wp_n_in,
   input wire logic rst_pin_n_in,
   input wire logic busy_in,
   input wire logic page_bin_in,
   input wire logic so_oe_out,
   input wire logic hold_reset_out,
   input wire logic hw_protect_out,
   input wire logic standby_out,
   input wire logic cmd_valid_out,
   input wire sfc_kind_e cmd_kind_out,
   input wire logic wr_valid_out,
   input wire logic [8:0] wr_off_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (reset_in);
   logic [7:0] wp_age_reg;
   logic [8:0] wr_last_reg;
   logic wr_seen_reg;
   logic cs_n_reg;
   logic [8:0] wr_next;
   // write-protect age, last write offset within the frame
   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         wp_age_reg <= 8'h00;
         wr_last_reg <= 9'h000;
         wr_seen_reg <= 1'b0;
         cs_n_reg <= 1'b1;
      end else begin
         wp_age_reg <= wp_n_in ? 8'h00 : wp_age_reg + {7'h00, ~&wp_age_reg};
         wr_last_reg <= wr_valid_out ? wr_off_out : wr_last_reg;
         wr_seen_reg <= (wr_seen_reg | wr_valid_out) & ~(cs_n_reg & ~cs_n_in);
         cs_n_reg <= cs_n_in;
      end
   end
   // next write offset, wrapping at the page end
   assign wr_next = (wr_last_reg == (page_bin_in ? `SFC_BIN_LAST :
      `SFC_STD_LAST)) ? 9'h000 : wr_last_reg + 9'h001;
   // link output, reset pin and protect flag
   property p_oe_idle; cs_n_in |-> !so_oe_out; endproperty
   a_oe_idle: assert property (p_oe_idle)
      else $error("so driven while deselected");
   property p_hold; !rst_pin_n_in [*4] |-> hold_reset_out; endproperty
   a_hold: assert property (p_hold)
      else $error("reset pin low not held");
   property p_prot_on; !wp_n_in [*4] |-> hw_protect_out; endproperty
   a_prot_on: assert property (p_prot_on)
      else $error("protect flag missing");
   property p_prot_off; wp_n_in [*4] |-> !hw_protect_out; endproperty
   a_prot_off: assert property (p_prot_off)
      else $error("protect flag with pin high");
   // long-settled protect only: the refusal may fall on the opcode
   property p_wp_refuse;
      cmd_valid_out && wp_age_reg == 8'hff |->
         cmd_kind_out inside {CK_READ, CK_PROT_ENABLE, CK_LOCKDOWN};
   endproperty
   a_wp_refuse: assert property (p_wp_refuse)
      else $error("command issued under write protect");
   // commands and standby follow deselect
   property p_cmd_desel; cmd_valid_out |-> $past(cs_n_in, 2); endproperty
   a_cmd_desel: assert property (p_cmd_desel)
      else $error("command issued while selected");
   property p_standby;
      (cs_n_in && !busy_in && rst_pin_n_in) [*5] |-> standby_out;
   endproperty
   a_standby: assert property (p_standby)
      else $error("standby missing");
   property p_busy; busy_in [*4] |-> !standby_out; endproperty
   a_busy: assert property (p_busy)
      else $error("standby while busy");
   property p_wr_wrap; wr_valid_out && wr_seen_reg |-> wr_off_out == wr_next;
   endproperty
   a_wr_wrap: assert property (p_wr_wrap)
      else $error("write offset left the page");
endmodule

// [tb/sfc_host_model.sv]
`timescale 1ns/100ps
module sfc_host_model (
   // link pins driven by the host
   output logic sclk_out,
   output logic cs_n_out,
   output logic si_out,
   // serial data from the device
   input wire logic so_in
);
   // idle link, clock parked
   initial begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      si_out = 1'b0;
   end
   // one framed instruction in mode 0 or 3, 160 ns clock
   task automatic frame(input int n, input logic m3,
         input logic [7:0] tx [8], output logic [7:0] rx [8]);
      sclk_out = m3;
      #37;
      cs_n_out = 1'b0;
      #80;
      for (int i = 0; i < n; i++) begin
         for (int b = 7; b >= 0; b--) begin
            sclk_out = 1'b0;
            si_out = tx[i][b];
            #80;
            rx[i][b] = so_in;
            sclk_out = 1'b1;
            #80;
         end
      end
      sclk_out = m3;
      #160;
      cs_n_out = 1'b1;
      si_out = ~si_out; // toggled line
      #240;
   endtask
endmodule

// [tb/serial_flash_command_front_end_tb.sv]
`timescale 1ns/100ps
`include "sfc_params.svh"
module serial_flash_command_front_end_tb
   import sfc_pkg::*;
;
   logic sys_clk_in, reset_in, sclk, cs_n, si, so, so_oe, so_line;
   logic wp_n, rst_pin_n, page_bin, busy, hw_prot, hold_rst, standby;
   logic cmd_valid, wr_valid, rd_req;
   sfc_kind_e cmd_kind;
   sfc_tgt_e cmd_tgt, rd_tgt;
   logic [11:0] cmd_page, rd_page, pg, ep;
   logic [8:0] cmd_off, wr_off, rd_off, of, eo, wr_last_off;
   logic [7:0] wr_data, wr_last_data;
   logic [7:0] rd_data = 8'h00;
   logic [7:0] tx [8];
   logic [7:0] rx [8];
   logic [31:0] seed = 32'h0000_0017;
   int err_total = 0, check_count = 0, cmd_cnt = 0, wr_cnt = 0;
   int ncmd = 0, nwr;
   logic [7:0] eop [6] = '{`SFC_OP_ERASE_PAGE, `SFC_OP_ERASE_BLOCK,
      `SFC_OP_ERASE_SECTOR, `SFC_OP_ERASE_CHIP, `SFC_OP_LOCKDOWN,
      `SFC_OP_PROT_ENABLE};
   sfc_kind_e ekd [6] = '{CK_ERASE_PAGE, CK_ERASE_BLOCK, CK_ERASE_SECTOR,
      CK_ERASE_CHIP, CK_LOCKDOWN, CK_PROT_ENABLE};
   int enb [6] = '{4, 4, 4, 1, 4, 1};
   logic [7:0] wop [5] = '{`SFC_OP_PROG_BUF1, `SFC_OP_PROT_WRITE,
      `SFC_OP_ERASE_CHIP, `SFC_OP_PROT_ENABLE, `SFC_OP_LOCKDOWN};
   int wnb [5] = '{6, 2, 1, 1, 4};
   logic [7:0] rop [3] = '{`SFC_OP_READ_MAIN, `SFC_OP_READ_BUF1,
      `SFC_OP_READ_BUF2};
   sfc_tgt_e rtg [3] = '{TGT_MAIN, TGT_BUF1, TGT_BUF2};

   sfc_front_end dut (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
      .sclk_in(sclk), .cs_n_in(cs_n), .si_in(si), .so_out(so),
      .so_oe_out(so_oe), .wp_n_in(wp_n), .rst_pin_n_in(rst_pin_n),
      .page_bin_in(page_bin), .busy_in(busy), .hw_protect_out(hw_prot),
      .hold_reset_out(hold_rst), .standby_out(standby),
      .cmd_valid_out(cmd_valid), .cmd_kind_out(cmd_kind),
      .cmd_tgt_out(cmd_tgt), .cmd_page_out(cmd_page), .cmd_off_out(cmd_off),
      .wr_valid_out(wr_valid), .wr_data_out(wr_data), .wr_off_out(wr_off),
      .rd_req_out(rd_req), .rd_tgt_out(rd_tgt), .rd_page_out(rd_page),
      .rd_off_out(rd_off), .rd_data_in(rd_data));
   // floating output line shows no stale bit
   assign so_line = so_oe ? so : ~so;
   sfc_host_model host (.sclk_out(sclk), .cs_n_out(cs_n), .si_out(si),
      .so_in(so_line));

   // system clock
   initial begin
      sys_clk_in = 1'b0;
      forever #25 sys_clk_in = ~sys_clk_in;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [7:0] dat(sfc_tgt_e t, logic [11:0] p,
         logic [8:0] o);
      return (t == TGT_MAIN ? p[7:0] : 8'h00) ^ o[7:0] ^ {5'h00, o[8], t};
   endfunction
   function automatic logic [23:0] adr(logic b, logic [11:0] p,
         logic [8:0] o);
      return b ? {4'h0, p, o[7:0]} : {3'h0, p, o};
   endfunction
   // array model, data one cycle after request; issue counters
   always @(posedge sys_clk_in) begin
      if (rd_req) rd_data <= dat(rd_tgt, rd_page, rd_off);
      if (cmd_valid) cmd_cnt <= cmd_cnt + 1;
      if (wr_valid) begin
         wr_cnt <= wr_cnt + 1;
         wr_last_off <= wr_off;
         wr_last_data <= wr_data;
      end
   end
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // one frame, then the running issue count
   task automatic send(logic [7:0] op, logic [23:0] a, int n, logic m3,
         int issue);
      tx[0] = op;
      tx[1] = a[23:16];
      tx[2] = a[15:8];
      tx[3] = a[7:0];
      for (int i = 4; i < 8; i++) tx[i] = 8'(rnd());
      host.frame(n, m3, tx, rx);
      repeat (20) @(posedge sys_clk_in);
      #2;
      ncmd += issue;
      check("cmd_count", cmd_cnt, ncmd);
   endtask

   // main sequence
   initial begin
      reset_in = 1'b1;
      wp_n = 1'b1;
      rst_pin_n = 1'b1;
      page_bin = 1'b0;
      busy = 1'b0;
      repeat (5) @(posedge sys_clk_in);
      #2;
      reset_in = 1'b0;
      // erase sizes, lockdown, protection enable, both page sizes
      for (int i = 0; i < 6; i++) begin
         page_bin = i[0];
         pg = 12'(rnd());
         of = 9'(rnd()) % (page_bin ? 9'h100 : 9'h108);
         send(eop[i], adr(page_bin, pg, of), enb[i], i[1], 1);
         check("kind", cmd_kind, ekd[i]);
         if (enb[i] == 4) begin
            check("page", cmd_page, pg);
            check("offset", cmd_off, of);
         end
      end
      // protect pin low: only protection enable and lockdown issue
      wp_n = 1'b0;
      repeat (300) @(posedge sys_clk_in);
      #2;
      nwr = wr_cnt;
      for (int i = 0; i < 5; i++)
         send(wop[i], 24'(rnd()), wnb[i], i[0], i > 2);
      check("wr_count", wr_cnt, nwr);
      wp_n = 1'b1;
      busy = 1'b1;
      send(`SFC_OP_ERASE_SECTOR, 24'h00_0000, 4, 1'b0, 0);
      busy = 1'b0;
      send(`SFC_OP_ERASE_PAGE, 24'h00_0000, 3, 1'b1, 0);
      // protection write accepted with the pin high; unknown opcode dropped
      nwr = wr_cnt + 1;
      send(`SFC_OP_PROT_WRITE, 24'h00_0000, 2, 1'b0, 1);
      check("kind", cmd_kind, CK_PROT_WRITE);
      check("wr_count", wr_cnt, nwr);
      send(8'hff, 24'h00_0000, 4, 1'b1, 0);
      // reset pin pulled low in mid-frame drops the frame
      fork
         send(`SFC_OP_ERASE_BLOCK, 24'h00_0000, 4, 1'b0, 0);
         begin
            repeat (40) @(posedge sys_clk_in);
            #2;
            rst_pin_n = 1'b0;
            repeat (5) @(posedge sys_clk_in);
            #2;
            check("hold_reset", hold_rst, 1'b1);
            check("so_enable", so_oe, 1'b0);
            repeat (80) @(posedge sys_clk_in);
            #2;
            rst_pin_n = 1'b1;
         end
      join
      // program from the last byte: offsets wrap inside the page
      for (int i = 0; i < 2; i++) begin
         page_bin = i[0];
         of = page_bin ? `SFC_BIN_LAST : `SFC_STD_LAST;
         nwr = wr_cnt + 2;
         send(i ? `SFC_OP_PROG_BUF2 : `SFC_OP_PROG_BUF1,
            adr(page_bin, 12'h000, of), 6, i[0], 1);
         check("kind", cmd_kind, CK_PROGRAM);
         check("target", cmd_tgt, i ? TGT_BUF2 : TGT_BUF1);
         check("wr_count", wr_cnt, nwr);
         check("wr_off", wr_last_off, 9'h000);
         check("wr_data", wr_last_data, tx[5]);
      end
      // reads over the page end from main memory and both buffers
      for (int i = 0; i < 3; i++) begin
         page_bin = i[0];
         pg = 12'(rnd());
         of = (page_bin ? `SFC_BIN_LAST : `SFC_STD_LAST) - 9'h001;
         send(rop[i], adr(page_bin, pg, of), 8, i[0], 0);
         for (int k = 0; k < 3; k++) begin
            ep = (k == 2 && rtg[i] == TGT_MAIN) ? pg + 12'h001 : pg;
            eo = (k == 2) ? 9'h000 : of + 9'(k);
            check("read", rx[5 + k], dat(rtg[i], ep, eo));
         end
      end
      final_report();
   end
endmodule

bind sfc_front_end sfc_fe_monitor mon (.sys_clk_in(sys_clk_in),
   .reset_in(reset_in), .cs_n_in(cs_n_in), .wp_n_in(wp_n_in),
   .rst_pin_n_in(rst_pin_n_in), .busy_in(busy_in),
   .page_bin_in(page_bin_in), .so_oe_out(so_oe_out),
   .hold_reset_out(hold_reset_out), .hw_protect_out(hw_protect_out),
   .standby_out(standby_out), .cmd_valid_out(cmd_valid_out),
   .cmd_kind_out(cmd_kind_out), .wr_valid_out(wr_valid_out),
   .wr_off_out(wr_off_out));
